//--- cmb_math_top.sv
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "cmb_defs.svh"
module cmb_math_top #(
  parameter int NBLK = 5,
  parameter int NIN = 6,
  parameter int NSTG = 4,
  parameter int unsigned UPD_CYCLES = `CMB_UPDATE_US * `CMB_CLK_MHZ
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Source signals from other function blocks
  input wire logic signed [31:0] in_value [NBLK*NIN],
  // Results to other function blocks
  output logic signed [31:0] out_value [NBLK],
  output logic [15:0] out_pct [NBLK],
  output logic signed [31:0] out_min [NBLK],
  output logic signed [31:0] out_max [NBLK]
);
  // Settings and results, one set per block; the run bit and the pass count are global
  logic signed [31:0] in_min_q [NBLK*NIN];
  logic signed [31:0] in_max_q [NBLK*NIN];
  logic [7:0] gain_q [NBLK*NIN];
  cmb_pkg::cmb_stage_t stage_q [NBLK*NSTG];
  logic signed [31:0] omin_q [NBLK];
  logic signed [31:0] omax_q [NBLK];
  logic signed [31:0] value_q [NBLK];
  logic [15:0] pct_q [NBLK];
  logic run_q;
  logic [15:0] upd_cnt_q;

  // Register read decode
  function automatic logic [32:0] reg_rd(input logic [11:0] a);
    logic [2:0] b;
    logic [4:0] w;
    int i;
    int s;
    b = a[9:7];
    w = a[6:2];
    i = int'(b) * NIN + int'(w[4:2]);
    s = int'(b) * NSTG + int'(w[1:0]);
    reg_rd = 33'h0;
    if (a[11:10] != 2'h0) begin
      reg_rd = 33'h0;
    end else if (b == `CMB_GLOBAL_BLK) begin
      if (w == `CMB_W_CTRL) reg_rd = {1'b1, 31'h0, run_q};
      else if (w == `CMB_W_STATUS) reg_rd = {1'b1, upd_cnt_q, 16'h0};
    end else if (int'(b) < NBLK) begin
      if (w < `CMB_W_STAGE0 && int'(w[4:2]) < NIN) begin
        case (w[1:0])
          `CMB_F_MIN: reg_rd = {1'b1, in_min_q[i]};
          `CMB_F_MAX: reg_rd = {1'b1, in_max_q[i]};
          `CMB_F_GAIN: reg_rd = {1'b1, 24'h0, gain_q[i]};
          default: reg_rd = 33'h0;
        endcase
      end else if (w >= `CMB_W_STAGE0 && w < `CMB_W_OMIN) begin
        reg_rd = {1'b1, 22'h0, stage_q[s]};
      end else if (w == `CMB_W_OMIN) reg_rd = {1'b1, omin_q[b]};
      else if (w == `CMB_W_OMAX) reg_rd = {1'b1, omax_q[b]};
      else if (w == `CMB_W_PCT) reg_rd = {1'b1, 16'h0, pct_q[b]};
      else if (w == `CMB_W_VALUE) reg_rd = {1'b1, value_q[b]};
    end
  endfunction

  // Write channel: address and data taken in either order
  logic aw_got_q;
  logic w_got_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_wr;
  logic [32:0] wr_old;
  logic [31:0] wr_mask;
  logic [31:0] wr_data;
  logic [2:0] wr_b;
  logic [4:0] wr_w;
  logic wr_cfg;
  int wr_i;
  int wr_s;
  assign s_axi_awready = !aw_got_q && !bvalid_q;
  assign s_axi_wready = !w_got_q && !bvalid_q;
  assign do_wr = aw_got_q && w_got_q;
  // The decode reads settings as well as the address, so it must wake on both
  always_comb wr_old = reg_rd(awaddr_q);
  assign wr_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_data = (wr_old[31:0] & ~wr_mask) | (wdata_q & wr_mask);
  assign wr_b = awaddr_q[9:7];
  assign wr_w = awaddr_q[6:2];
  assign wr_cfg = do_wr && wr_old[32] && int'(wr_b) < NBLK;
  assign wr_i = int'(wr_b) * NIN + int'(wr_w[4:2]);
  assign wr_s = int'(wr_b) * NSTG + int'(wr_w[1:0]);
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `CMB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_old[32] ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Settings storage; read-only words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NBLK * NIN; i++) begin
        in_min_q[i] <= `CMB_RST_IN_MIN;
        in_max_q[i] <= `CMB_RST_IN_MAX;
        gain_q[i] <= `CMB_RST_GAIN;
      end
      for (int s = 0; s < NBLK * NSTG; s++) stage_q[s] <= '0;
      for (int b = 0; b < NBLK; b++) begin
        omin_q[b] <= `CMB_RST_OMIN;
        omax_q[b] <= `CMB_RST_OMAX;
      end
      run_q <= `CMB_RST_CTRL;
    end else if (do_wr && wr_old[32]) begin
      if (wr_b == `CMB_GLOBAL_BLK && wr_w == `CMB_W_CTRL) run_q <= wr_data[0];
      if (wr_cfg && wr_w < `CMB_W_STAGE0) begin
        case (wr_w[1:0])
          `CMB_F_MIN: in_min_q[wr_i] <= wr_data;
          `CMB_F_MAX: in_max_q[wr_i] <= wr_data;
          `CMB_F_GAIN: gain_q[wr_i] <= wr_data[7:0];
          default: ;
        endcase
      end
      if (wr_cfg && wr_w >= `CMB_W_STAGE0 && wr_w < `CMB_W_OMIN) stage_q[wr_s] <= wr_data[9:0];
      if (wr_cfg && wr_w == `CMB_W_OMIN) omin_q[wr_b] <= wr_data;
      if (wr_cfg && wr_w == `CMB_W_OMAX) omax_q[wr_b] <= wr_data;
    end
  end

  // Read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [32:0] rd_word;
  always_comb rd_word = reg_rd(s_axi_araddr);
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `CMB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word[31:0];
      rresp_q <= rd_word[32] ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Update tick divider
  logic [31:0] div_q;
  logic tick;
  assign tick = div_q == UPD_CYCLES - 1;
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) div_q <= 32'h0;
    else div_q <= div_q + 32'h1;
  end

  // One shared scaler and ALU walk all blocks in turn, trading speed for area
  cmb_pkg::cmb_state_t state_q;
  logic [2:0] blk_q;
  logic [2:0] idx_q;
  logic [15:0] scaled_q [NIN];
  logic [15:0] acc_q;
  int in_i;
  cmb_pkg::cmb_stage_t cfg;
  assign in_i = int'(blk_q) * NIN + int'(idx_q);
  assign cfg = stage_q[int'(blk_q) * NSTG + int'(idx_q[1:0])];

  // Input to percent: clamp, then ratio within the span
  logic signed [32:0] span;
  logic signed [32:0] xoff;
  logic [7:0] gain_eff;
  logic [63:0] num;
  logic [63:0] den;
  logic [15:0] scale_pct;
  assign span = 33'(in_max_q[in_i]) - 33'(in_min_q[in_i]);
  assign xoff = (in_value[in_i] <= in_min_q[in_i]) ? 33'sh0 :
    (in_value[in_i] >= in_max_q[in_i]) ? span :
    33'(in_value[in_i]) - 33'(in_min_q[in_i]);
  assign gain_eff = (gain_q[in_i] == 8'h00) ? 8'h01 : gain_q[in_i];
  assign num = 64'(xoff) * 64'(gain_eff) * 64'(`CMB_PCT_FULL);
  assign den = 64'(span) * 64'(gain_eff);
  assign scale_pct = (span <= 33'sh0) ? 16'h0000 : 16'(num / den);

  // Stage operands
  logic [15:0] alu_a;
  logic [15:0] alu_b;
  logic [15:0] alu_res;
  logic b_used;
  assign alu_a = (idx_q != 3'h0) ? acc_q :
    (cfg.a_sel == 3'h0 || int'(cfg.a_sel) > NIN) ? 16'h0000 : scaled_q[cfg.a_sel - 3'h1];
  assign b_used = cfg.b_sel != 3'h0 && int'(cfg.b_sel) <= NIN;
  assign alu_b = b_used ? scaled_q[cfg.b_sel - 3'h1] : 16'h0000;

  cmb_stage_alu u_alu (
    .op(cfg.op),
    .b_used(b_used),
    .operand_a(alu_a),
    .operand_b(alu_b),
    .result(alu_res)
  );

  // Percent to output units
  logic signed [63:0] map_val;
  // Signed throughout so a falling output range maps correctly
  assign map_val = 64'(omin_q[blk_q]) +
    (64'(signed'({1'b0, acc_q})) * (64'(omax_q[blk_q]) - 64'(omin_q[blk_q])))
    / 64'(signed'({1'b0, `CMB_PCT_FULL}));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= cmb_pkg::CMB_IDLE;
      blk_q <= 3'h0;
      idx_q <= 3'h0;
      acc_q <= 16'h0000;
      upd_cnt_q <= 16'h0000;
      for (int k = 0; k < NIN; k++) scaled_q[k] <= 16'h0000;
      for (int b = 0; b < NBLK; b++) begin
        value_q[b] <= 32'h0;
        pct_q[b] <= 16'h0000;
      end
    end else begin
      case (state_q)
        cmb_pkg::CMB_IDLE: begin
          if (tick && run_q) begin
            state_q <= cmb_pkg::CMB_SCALE;
            blk_q <= 3'h0;
            idx_q <= 3'h0;
          end
        end
        cmb_pkg::CMB_SCALE: begin
          scaled_q[idx_q] <= scale_pct;
          idx_q <= (int'(idx_q) == NIN - 1) ? 3'h0 : idx_q + 3'h1;
          if (int'(idx_q) == NIN - 1) state_q <= cmb_pkg::CMB_STAGE;
        end
        cmb_pkg::CMB_STAGE: begin
          acc_q <= alu_res;
          idx_q <= (int'(idx_q) == NSTG - 1) ? 3'h0 : idx_q + 3'h1;
          if (int'(idx_q) == NSTG - 1) state_q <= cmb_pkg::CMB_MAP;
        end
        cmb_pkg::CMB_MAP: begin
          value_q[blk_q] <= map_val[31:0];
          pct_q[blk_q] <= acc_q;
          blk_q <= (int'(blk_q) == NBLK - 1) ? 3'h0 : blk_q + 3'h1;
          if (int'(blk_q) == NBLK - 1) begin
            state_q <= cmb_pkg::CMB_IDLE;
            upd_cnt_q <= upd_cnt_q + 16'h0001;
          end else begin
            state_q <= cmb_pkg::CMB_SCALE;
          end
        end
        default: state_q <= cmb_pkg::CMB_IDLE;
      endcase
    end
  end

  assign out_value = value_q;
  assign out_pct = pct_q;
  assign out_min = omin_q;
  assign out_max = omax_q;

  a_logic_is_bool: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == cmb_pkg::CMB_STAGE && b_used && cfg.op <= 4'h8
    |-> alu_res == 16'h0000 || alu_res == `CMB_PCT_ONE)
    else $error("logic stage result not 0 or 1");
  a_div_zero_full: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == cmb_pkg::CMB_STAGE && b_used && cfg.op == 4'hc && alu_b == 16'h0000
    |=> acc_q == `CMB_PCT_FULL)
    else $error("divide by zero did not give full scale");
  a_unused_passes_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == cmb_pkg::CMB_STAGE && !b_used |=> acc_q == $past(alu_a))
    else $error("unused stage altered operand A");
  a_result_in_range: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == cmb_pkg::CMB_STAGE |=> acc_q <= `CMB_PCT_FULL)
    else $error("stage result beyond full scale");
  a_chain_feeds_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == cmb_pkg::CMB_STAGE && idx_q != 3'h0 |-> alu_a == acc_q)
    else $error("later stage did not take previous result");
  a_update_starts: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == cmb_pkg::CMB_IDLE && tick && run_q
    |=> state_q == cmb_pkg::CMB_SCALE ##6 state_q == cmb_pkg::CMB_STAGE
    ##4 state_q == cmb_pkg::CMB_MAP)
    else $error("update sequence out of step");
  a_max_maps_top: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == cmb_pkg::CMB_MAP && acc_q == `CMB_PCT_FULL
    |=> value_q[$past(blk_q)] == $past(omax_q[blk_q]))
    else $error("full percent did not map to output maximum");
  a_scale_in_range: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == cmb_pkg::CMB_SCALE |=> scaled_q[$past(idx_q)] <= `CMB_PCT_FULL)
    else $error("scaled input beyond full scale");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response missing");
endmodule

//--- cmb_defs.svh
`ifndef CMB_DEFS_SVH
`define CMB_DEFS_SVH
// Percent scale: one unit is 0.01 %
`define CMB_PCT_ONE 16'h0064
`define CMB_PCT_FULL 16'h2710
// Processing update period
`define CMB_UPDATE_US 1000
`define CMB_CLK_MHZ 50
// Word indices inside one block window
`define CMB_W_STAGE0 5'h18
`define CMB_W_OMIN 5'h1c
`define CMB_W_OMAX 5'h1d
`define CMB_W_PCT 5'h1e
`define CMB_W_VALUE 5'h1f
`define CMB_F_MIN 2'h0
`define CMB_F_MAX 2'h1
`define CMB_F_GAIN 2'h2
// Global window and its words
`define CMB_GLOBAL_BLK 3'h5
`define CMB_W_CTRL 5'h00
`define CMB_W_STATUS 5'h01
// Reset values
`define CMB_RST_IN_MIN 32'h0000_0000
`define CMB_RST_IN_MAX 32'h0000_0064
`define CMB_RST_GAIN 8'h01
`define CMB_RST_OMIN 32'h0000_0000
`define CMB_RST_OMAX 32'h0000_0064
`define CMB_RST_CTRL 1'h1
// Bus responses
`define CMB_RESP_OKAY 2'h0
`define CMB_RESP_SLVERR 2'h2
`endif

//--- cmb_pkg.sv
package cmb_pkg;
  typedef enum logic [3:0] {
    CMB_EQ, CMB_NE, CMB_GT, CMB_GE, CMB_LT, CMB_LE, CMB_OR, CMB_AND, CMB_XOR,
    CMB_ADD, CMB_SUB, CMB_MUL, CMB_DIV, CMB_MIN, CMB_MAX, CMB_NOP
  } cmb_op_t;
  typedef struct packed {
    logic [2:0] a_sel;
    logic [2:0] b_sel;
    logic [3:0] op;
  } cmb_stage_t;
  typedef enum logic [1:0] {CMB_IDLE, CMB_SCALE, CMB_STAGE, CMB_MAP} cmb_state_t;
endpackage

//--- cmb_stage_alu.sv
`timescale 1ns/1ps
`include "cmb_defs.svh"
module cmb_stage_alu (
  // Stage setting
  input wire logic [3:0] op,
  input wire logic b_used,
  // Operands in percent units
  input wire logic [15:0] operand_a,
  input wire logic [15:0] operand_b,
  // Result
  output logic [15:0] result
);
  logic a_true;
  logic b_true;
  logic [31:0] wide;
  assign a_true = operand_a >= `CMB_PCT_ONE;
  assign b_true = operand_b >= `CMB_PCT_ONE;
  always_comb begin
    wide = {16'h0000, operand_a};
    case (op)
      cmb_pkg::CMB_EQ: wide = (operand_a == operand_b) ? 32'h64 : 32'h0;
      cmb_pkg::CMB_NE: wide = (operand_a != operand_b) ? 32'h64 : 32'h0;
      cmb_pkg::CMB_GT: wide = (operand_a > operand_b) ? 32'h64 : 32'h0;
      cmb_pkg::CMB_GE: wide = (operand_a >= operand_b) ? 32'h64 : 32'h0;
      cmb_pkg::CMB_LT: wide = (operand_a < operand_b) ? 32'h64 : 32'h0;
      cmb_pkg::CMB_LE: wide = (operand_a <= operand_b) ? 32'h64 : 32'h0;
      cmb_pkg::CMB_OR: wide = (a_true || b_true) ? 32'h64 : 32'h0;
      cmb_pkg::CMB_AND: wide = (a_true && b_true) ? 32'h64 : 32'h0;
      cmb_pkg::CMB_XOR: wide = (a_true ^ b_true) ? 32'h64 : 32'h0;
      cmb_pkg::CMB_ADD: wide = {16'h0000, operand_a} + {16'h0000, operand_b};
      cmb_pkg::CMB_SUB: begin
        // Floor at zero rather than wrap
        wide = (operand_a < operand_b) ? 32'h0 : {16'h0000, operand_a - operand_b};
      end
      cmb_pkg::CMB_MUL: begin
        wide = ({16'h0000, operand_a} * {16'h0000, operand_b}) / {16'h0000, `CMB_PCT_ONE};
      end
      cmb_pkg::CMB_DIV: begin
        if (operand_b == 16'h0000) begin
          wide = {16'h0000, `CMB_PCT_FULL};
        end else begin
          wide = ({16'h0000, operand_a} * {16'h0000, `CMB_PCT_ONE}) / {16'h0000, operand_b};
        end
      end
      cmb_pkg::CMB_MIN: wide = {16'h0000, (operand_a < operand_b) ? operand_a : operand_b};
      cmb_pkg::CMB_MAX: wide = {16'h0000, (operand_a > operand_b) ? operand_a : operand_b};
      default: wide = {16'h0000, operand_a};
    endcase
  end
  // Saturate, or pass operand A through when B is unused
  assign result = !b_used ? operand_a :
    (wide > {16'h0000, `CMB_PCT_FULL}) ? `CMB_PCT_FULL : wide[15:0];
endmodule

//--- cmb_src_model.sv
`timescale 1ns/1ps
module cmb_src_model #(
  parameter int N = 30
) (
  // Clock
  input wire logic aclk,
  // Source values towards the block
  output logic signed [31:0] in_value [N]
);
  logic signed [31:0] next_v [N];
  initial begin
    for (int i = 0; i < N; i++) begin
      next_v[i] = '0;
    end
  end
  // Callers keep values inside each input's span, so results stay in 0..100 %
  task automatic set_src(input int idx, input logic signed [31:0] v);
    next_v[idx] = v;
  endtask
  // Launched only at clock edges; the bench waits two passes after any change
  always @(posedge aclk) begin
    for (int i = 0; i < N; i++) in_value[i] <= next_v[i];
  end
endmodule

//--- tb_chained_math_function_block.sv
`timescale 1ns/1ps
module tb_chained_math_function_block;
  logic aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic signed [31:0] in_value [30];
  logic signed [31:0] out_value [5];
  logic [15:0] out_pct [5];
  logic signed [31:0] out_min [5];
  logic signed [31:0] out_max [5];
  int fails, comparisons;

  cmb_math_top #(.UPD_CYCLES(80)) cmb_math_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .in_value(in_value), .out_value(out_value), .out_pct(out_pct),
    .out_min(out_min), .out_max(out_max)
  );
  cmb_src_model cmb_src_model_i (.aclk(aclk), .in_value(in_value));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic finish_test;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic hang(input string what);
    fails++;
    $display("[ERR] %0t no answer on %s", $time, what);
    finish_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; !(aw_ok && w_ok); n++) begin
      if (n > 50) hang("aw/w");
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    for (int n = 0; 1; n++) begin
      if (n > 50) hang("b");
      @(posedge aclk);
      if (bvalid) break;
    end
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; 1; n++) begin
      if (n > 50) hang("ar");
      @(posedge aclk);
      if (arready) break;
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    for (int n = 0; 1; n++) begin
      if (n > 50) hang("r");
      @(posedge aclk);
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Two completed passes, so one pass saw only settled sources and settings
  task automatic wait_pass;
    logic [15:0] base;
    axi_read(12'h284, rd, rs);
    base = rd[31:16];
    for (int n = 0; rd[31:16] - base < 16'h0002; n++) begin
      if (n > 500) hang("update");
      axi_read(12'h284, rd, rs);
    end
  endtask

  function automatic logic [15:0] exp_op(input int op, input int a, input int b);
    bit ta, tb;
    int r;
    ta = a >= 100;
    tb = b >= 100;
    case (op)
      0: r = (a == b) ? 100 : 0;
      1: r = (a != b) ? 100 : 0;
      2: r = (a > b) ? 100 : 0;
      3: r = (a >= b) ? 100 : 0;
      4: r = (a < b) ? 100 : 0;
      5: r = (a <= b) ? 100 : 0;
      6: r = (ta || tb) ? 100 : 0;
      7: r = (ta && tb) ? 100 : 0;
      8: r = (ta != tb) ? 100 : 0;
      9: r = a + b;
      10: r = a - b;
      11: r = a * b / 100;
      12: r = (b == 0) ? 10000 : a * 100 / b;
      13: r = (a < b) ? a : b;
      14: r = (a > b) ? a : b;
      default: r = a;
    endcase
    if (r < 0) r = 0;
    if (r > 10000) r = 10000;
    return 16'(r);
  endfunction

  // Stage one: A from input 1, B from input 2; later stages left unused
  task automatic do_case(input int blk, input int op, input int ai, input int bi, input int sa,
                         input int sb);
    logic [15:0] e;
    e = exp_op(op, sa, sb);
    cmb_src_model_i.set_src(blk * 6, ai);
    cmb_src_model_i.set_src(blk * 6 + 1, bi);
    axi_write(12'(blk * 128 + 'h60), 32'(op + (2 << 4) + (1 << 7)), 2'h0);
    wait_pass();
    chk({16'h0, out_pct[blk]}, {16'h0, e}, "pct");
    chk(out_value[blk], {16'h0, e / 16'd100}, "value");
  endtask

  task automatic t_reset;
    logic [11:0] ra [6] = '{12'h000, 12'h004, 12'h008, 12'h070, 12'h074, 12'h280};
    logic [31:0] rv [6] = '{32'h0, 32'h64, 32'h1, 32'h0, 32'h64, 32'h1};
    logic [31:0] held;
    for (int b = 0; b < 5; b++) begin
      chk(out_max[b], 32'h64, "omax");
      chk(out_min[b], 32'h0, "omin");
    end
    for (int i = 0; i < 6; i++) begin
      axi_read(ra[i], rd, rs);
      chk(rd, rv[i], "reset reg");
    end
    axi_read(12'h300, rd, rs);
    chk({30'h0, rs}, 32'h2, "unmapped resp");
    chk(rd, 32'h0, "unmapped data");
    axi_write(12'h300, 32'h1234, 2'h2);
    axi_write(12'h078, 32'h1234, 2'h0);
    axi_read(12'h078, rd, rs);
    chk(rd, 32'h0, "ro write ignored");
    // Stopping the run must freeze the pass count
    axi_write(12'h280, 32'h0, 2'h0);
    repeat (100) @(posedge aclk);
    axi_read(12'h284, rd, rs);
    held = rd;
    repeat (100) @(posedge aclk);
    axi_read(12'h284, rd, rs);
    chk(rd, held, "halted count");
    axi_write(12'h280, 32'h1, 2'h0);
  endtask

  task automatic t_ops;
    int xo [7] = '{12, 9, 10, 3, 2, 8, 5};
    int xa [7] = '{40, 70, 25, 40, 40, 40, 40};
    int xb [7] = '{0, 60, 40, 40, 40, 0, 40};
    for (int op = 0; op < 15; op++) begin
      do_case(0, op, 40, 25, 4000, 2500);
    end
    for (int i = 0; i < 7; i++) begin
      do_case(0, xo[i], xa[i], xb[i], xa[i] * 100, xb[i] * 100);
    end
  endtask

  // Input 2 span widened so one count is 0.01 %
  task automatic t_logic_edge;
    axi_write(12'h014, 32'h2710, 2'h0);
    do_case(0, 7, 40, 99, 4000, 99);
    do_case(0, 7, 40, 100, 4000, 100);
    do_case(0, 6, 0, 99, 0, 99);
    axi_write(12'h014, 32'h64, 2'h0);
  endtask

  task automatic t_blocks;
    for (int b = 0; b < 5; b++) begin
      do_case(b, 9, 10 + b, 20, 1000 + b * 100, 2000);
    end
  endtask

  task automatic t_chain;
    logic [15:0] e;
    e = exp_op(13, exp_op(10, exp_op(9, 5000, 3000), 2000), 4500);
    cmb_src_model_i.set_src(6, 50);
    cmb_src_model_i.set_src(7, 30);
    cmb_src_model_i.set_src(8, 20);
    cmb_src_model_i.set_src(9, 45);
    axi_write(12'h0e0, 32'(9 + (2 << 4) + (1 << 7)), 2'h0);
    axi_write(12'h0e4, 32'(10 + (3 << 4)), 2'h0);
    axi_write(12'h0e8, 32'(11), 2'h0);
    axi_write(12'h0ec, 32'(13 + (4 << 4)), 2'h0);
    wait_pass();
    chk({16'h0, out_pct[1]}, {16'h0, e}, "chain pct");
    chk(out_value[1], {16'h0, e / 16'd100}, "chain value");
    axi_read(12'h0f8, rd, rs);
    chk(rd, {16'h0, e}, "chain pct reg");
  endtask

  task automatic t_map;
    axi_write(12'h1f0, 32'hffff_ff9c, 2'h0);
    axi_write(12'h1f4, 32'h12c, 2'h0);
    cmb_src_model_i.set_src(18, 50);
    cmb_src_model_i.set_src(19, 0);
    axi_write(12'h1e0, 32'(9 + (2 << 4) + (1 << 7)), 2'h0);
    axi_write(12'h188, 32'h10, 2'h0);
    wait_pass();
    chk(out_min[3], 32'hffff_ff9c, "omin port");
    chk(out_max[3], 32'h12c, "omax port");
    chk(out_value[3], 32'h64, "mapped value");
    axi_read(12'h1fc, rd, rs);
    chk(rd, 32'h64, "value reg");
  endtask

  initial begin
    fails = 0;
    comparisons = 0;
    aresetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ops();
    t_logic_edge();
    t_blocks();
    t_chain();
    t_map();
    finish_test();
  end
endmodule
